// File: src/mvc_regs.sv
// Purpose: interrupt-message, product-data and vendor capability registers
// Assumes: APB slave on pclk; EEPROM engine answers with rom_done pulse
// Notes:   is_upstream selects which capability set is present
`timescale 1ns/1ps

module mvc_regs
  import mvc_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // strap, from a pin
  input  wire logic               is_upstream,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // eeprom table engine
  output mvc_pkg::mvc_rom_req_s   rom_req,
  input  wire logic               rom_done,
  input  wire logic [31:0]        rom_rdata,
  // interrupt signalling
  input  wire logic               irq_event,
  output logic                    legacy_int_n,
  output logic                    msg_req,
  output logic      [63:0]        msg_target,
  output logic      [15:0]        msg_payload
);

  // ----------------------------------------------------------------
  // strap and engine-done synchronisers
  // ----------------------------------------------------------------
  logic up_meta_reg;
  logic up_reg;
  logic rom_done_meta_reg;
  logic rom_done_reg;
  logic rom_done_prev_reg;
  logic rom_done_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_meta_reg <= 1'b0;
      up_reg      <= 1'b0;
    end
    else
    begin
      up_meta_reg <= is_upstream;
      up_reg      <= up_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rom_done_meta_reg <= 1'b0;
      rom_done_reg      <= 1'b0;
    end
    else
    begin
      rom_done_meta_reg <= rom_done;
      rom_done_reg      <= rom_done_meta_reg;
    end
  end

  // one completion per engine cycle, even if done is held high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rom_done_prev_reg <= 1'b0;
    else
      rom_done_prev_reg <= rom_done_reg;
  end

  assign rom_done_rise = rom_done_reg && !rom_done_prev_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic        hit_msg;
  logic        hit_pd;
  logic        mapped;
  logic        sel_ctrl;
  logic        sel_addr;
  logic        sel_uaddr;
  logic        sel_data;
  logic        sel_pd_cmd;
  logic        sel_pd_word;
  logic        sel_vendor;
  logic        sel_test0;

  function automatic logic is_msg_off(input logic [7:0] a);
    is_msg_off = (a == OFF_MSG_CTRL) || (a == OFF_MSG_ADDR) ||
                 (a == OFF_MSG_UADDR) || (a == OFF_MSG_DATA);
  endfunction

  function automatic logic is_pd_off(input logic [7:0] a);
    is_pd_off = (a == OFF_PD_ADDR) || (a == OFF_PD_WORD);
  endfunction

  assign hit_msg = is_msg_off(paddr) && !up_reg;
  assign hit_pd  = is_pd_off(paddr) && up_reg;
  assign mapped  = hit_msg || hit_pd || (paddr == OFF_VENDOR) || (paddr == OFF_TEST0);
  assign wr_en   = psel && penable && pwrite && !pready;
  assign rd_en   = psel && penable && !pwrite && !pready;

  // one strobe per word; message and test word writes decode paddr again
  assign sel_ctrl    = hit_msg && (paddr == OFF_MSG_CTRL);
  assign sel_addr    = hit_msg && (paddr == OFF_MSG_ADDR);
  assign sel_uaddr   = hit_msg && (paddr == OFF_MSG_UADDR);
  assign sel_data    = hit_msg && (paddr == OFF_MSG_DATA);
  assign sel_pd_cmd  = hit_pd && (paddr == OFF_PD_ADDR);
  assign sel_pd_word = hit_pd && (paddr == OFF_PD_WORD);
  assign sel_vendor  = (paddr == OFF_VENDOR);
  assign sel_test0   = (paddr == OFF_TEST0);

  // ----------------------------------------------------------------
  // message capability registers
  // ----------------------------------------------------------------
  logic        msg_en_reg;
  logic [2:0]  mme_reg;
  logic [29:0] msg_addr_reg;
  logic [31:0] msg_uaddr_reg;
  logic [15:0] msg_data_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msg_en_reg    <= 1'b0;
      mme_reg       <= 3'h0;
      msg_addr_reg  <= 30'h0;
      msg_uaddr_reg <= 32'h0;
      msg_data_reg  <= 16'h0;
    end
    else if (wr_en && hit_msg)
    begin
      if (paddr == OFF_MSG_CTRL)
      begin
        msg_en_reg <= pwdata[MSG_EN_BIT];
        mme_reg    <= pwdata[MME_LSB +: 3];
      end
      else if (paddr == OFF_MSG_ADDR)
        msg_addr_reg <= pwdata[31:2];
      else if (paddr == OFF_MSG_UADDR)
        msg_uaddr_reg <= pwdata;
      else
        msg_data_reg <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // product-data registers and table engine handshake
  // ----------------------------------------------------------------
  logic [5:0]  pd_addr_reg;
  logic        pd_flag_reg;
  logic        pd_busy_reg;
  logic [31:0] pd_word_reg;
  logic        rom_req_reg;
  logic        pd_cmd_take;

  // flag word writes are dropped without an error while a table cycle is pending
  assign pd_cmd_take = wr_en && sel_pd_cmd && !pd_busy_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_addr_reg <= 6'h0;
      pd_flag_reg <= 1'b0;
      pd_busy_reg <= 1'b0;
      rom_req_reg <= 1'b0;
    end
    else
    begin
      rom_req_reg <= 1'b0;
      if (pd_busy_reg && rom_done_rise)
      begin
        pd_busy_reg <= 1'b0;
        pd_flag_reg <= !pd_flag_reg;
      end
      else if (pd_cmd_take)
      begin
        pd_addr_reg <= pwdata[PD_ADDR_LSB +: 6];
        pd_flag_reg <= pwdata[PD_FLAG_BIT];
        pd_busy_reg <= 1'b1;
        rom_req_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pd_word_reg <= 32'h0;
    else if (pd_busy_reg && rom_done_rise && !pd_flag_reg)
      pd_word_reg <= rom_rdata;
    else if (wr_en && sel_pd_word)
      pd_word_reg <= pwdata;
  end

  assign rom_req.req   = rom_req_reg;
  assign rom_req.write = pd_flag_reg;
  assign rom_req.addr  = pd_addr_reg;
  assign rom_req.wdata = pd_word_reg;

  // ----------------------------------------------------------------
  // test word
  // ----------------------------------------------------------------
  logic [31:0] test0_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      test0_reg <= TEST0_RESET;
    else if (wr_en && paddr == OFF_TEST0)
      test0_reg <= pwdata;
  end

  // ----------------------------------------------------------------
  // read mux and bus answer
  // ----------------------------------------------------------------
  logic [31:0] rd_next;

  // control word: enable, multiple-message enable, fixed 64-bit capability
  function automatic logic [31:0] ctrl_view(input logic [2:0] mme, input logic en);
    ctrl_view = {8'h00, ADDR64_CAPABLE, mme, 3'h0, en, NEXT_PTR_VEND, CAP_ID_MSG};
  endfunction

  // address and flag word behind the product-data header
  function automatic logic [31:0] pd_view(input logic flag, input logic [5:0] addr);
    pd_view = {flag, 7'h00, addr, 2'b00, NEXT_PTR_VEND, CAP_ID_PD};
  endfunction

  always_comb
  begin
    rd_next = 32'h0;
    if (sel_ctrl)
      rd_next = ctrl_view(mme_reg, msg_en_reg);
    else if (sel_addr)
      rd_next = {msg_addr_reg, 2'b00};
    else if (sel_uaddr)
      rd_next = msg_uaddr_reg;
    else if (sel_data)
      rd_next = {16'h0000, msg_data_reg};
    else if (sel_pd_cmd)
      rd_next = pd_view(pd_flag_reg, pd_addr_reg);
    else if (sel_pd_word)
      rd_next = pd_word_reg;
    else if (sel_vendor)
      rd_next = {VENDOR_LENGTH, NEXT_PTR_SSID, CAP_ID_VENDOR};
    else if (sel_test0)
      rd_next = test0_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // read data stands until the next read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_en)
      prdata <= rd_next;
  end

  // ----------------------------------------------------------------
  // interrupt signalling
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      msg_req <= 1'b0;
    else
      msg_req <= irq_event && msg_en_reg && !up_reg;
  end

  // legacy pin stays released while messages are enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      legacy_int_n <= 1'b1;
    else
      legacy_int_n <= !(irq_event && !msg_en_reg);
  end

  // upper word takes part only with 64-bit message addressing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msg_target  <= 64'h0;
      msg_payload <= 16'h0;
    end
    else
    begin
      msg_target  <= {ADDR64_CAPABLE ? msg_uaddr_reg : 32'h0, msg_addr_reg, 2'b00};
      msg_payload <= msg_data_reg;
    end
  end

endmodule

// File: src/mvc_pkg.sv
// Purpose: constants and types for the capability register bank
// Assumes: APB with 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package mvc_pkg;

  localparam logic [7:0]  OFF_MSG_CTRL   = 8'h4C;
  localparam logic [7:0]  OFF_MSG_ADDR   = 8'h50;
  localparam logic [7:0]  OFF_MSG_UADDR  = 8'h54;
  localparam logic [7:0]  OFF_MSG_DATA   = 8'h58;
  localparam logic [7:0]  OFF_PD_ADDR    = 8'h5C;
  localparam logic [7:0]  OFF_PD_WORD    = 8'h60;
  localparam logic [7:0]  OFF_VENDOR     = 8'h64;
  localparam logic [7:0]  OFF_TEST0      = 8'h68;

  localparam logic [7:0]  CAP_ID_MSG     = 8'h05;
  localparam logic [7:0]  CAP_ID_PD      = 8'h03;
  localparam logic [7:0]  CAP_ID_VENDOR  = 8'h09;
  localparam logic [7:0]  NEXT_PTR_VEND  = 8'h64;
  localparam logic [7:0]  NEXT_PTR_SSID  = 8'hB0;
  localparam logic [15:0] VENDOR_LENGTH  = 16'h0034;
  localparam logic [31:0] TEST0_RESET    = 32'h0400_1060;

  // field positions
  localparam int          MSG_EN_BIT     = 16;
  localparam int          MME_LSB        = 20;
  localparam int          ADDR64_BIT     = 23;
  localparam int          PD_ADDR_LSB    = 18;
  localparam int          PD_FLAG_BIT    = 31;
  localparam logic        ADDR64_CAPABLE = 1'b1;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } mvc_access_s;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } mvc_rom_req_s;

endpackage

// File: sim/mvc_properties.sv
// Purpose: port checks for mvc_regs
// Assumes: three-cycle apb transfers (setup, one wait, ready), pulsed engine requests
// Notes:   bound to every mvc_regs instance
`timescale 1ns/1ps
module mvc_props
  import mvc_pkg::*;
(
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // watched ports
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire mvc_pkg::mvc_rom_req_s rom_req,
  input wire logic                  irq_event,
  input wire logic                  legacy_int_n,
  input wire logic                  msg_req,
  input wire logic [63:0]           msg_target
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  chk_ready_due: assert property (s_wait |=> s_done)
    else $error("ready not one pulse after access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_legacy_cause: assert property (!legacy_int_n |-> $past(irq_event) && !msg_req)
    else $error("legacy pin without cause");
  chk_msg_cause: assert property (msg_req |-> $past(irq_event) && legacy_int_n)
    else $error("message without cause");
  chk_target_align: assert property (!$stable(msg_target)
    |-> $past(pready && pwrite) && msg_target[1:0] == 2'b00)
    else $error("message target moved without write or unaligned");
  chk_rom_pulse: assert property (rom_req.req |=> !rom_req.req)
    else $error("engine request too long");
  chk_rom_cause: assert property (rom_req.req |-> $past(pwrite) || $past(pwrite, 2))
    else $error("engine request without write");
endmodule

bind mvc_regs mvc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .rom_req, .irq_event, .legacy_int_n, .msg_req, .msg_target);

// File: sim/mvc_rom_model.sv
// Purpose: behavioural product-data table behind the engine port
// Assumes: one request at a time
// Notes:   read data inverted once the answer window ends
`timescale 1ns/1ps
module mvc_rom_model
  import mvc_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // engine side
  input  wire mvc_pkg::mvc_rom_req_s rom_req,
  input  wire logic [3:0]            wait_cycles,
  output logic                       rom_done,
  output logic [31:0]                rom_rdata
);
  logic [31:0]  mem [64];
  mvc_rom_req_s cur;
  logic [4:0]   cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 5'h00;
    else if (rom_req.req)
      cnt <= {1'b0, wait_cycles} + 5'h06;
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
  always_ff @(posedge pclk)
  begin
    if (rom_req.req)
      cur <= rom_req;
    if (cnt == 5'h06 && cur.write)
      mem[cur.addr] <= cur.wdata;
    if (cnt == 5'h06 && !cur.write)
      rom_rdata <= mem[cur.addr];
    if (cnt == 5'h02)
      rom_rdata <= ~rom_rdata;
  end
  // done held four cycles, data stable throughout
  assign rom_done = (cnt >= 5'h02) && (cnt <= 5'h05);
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench for mvc_regs
// Assumes: strap changed only under reset
// Notes:   table answers come from mvc_rom_model
`timescale 1ns/1ps
module tb_top;
  import mvc_pkg::*;
  logic         pclk = 1'b0, presetn = 1'b0, is_upstream = 1'b1, irq_event = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, rd, prdata, rom_rdata;
  logic [3:0]   wait_cycles = 4'h1;
  logic         pready, pslverr, rom_done, legacy_int_n, msg_req;
  logic [63:0]  msg_target;
  logic [15:0]  msg_payload;
  mvc_rom_req_s rom_req;
  int           mismatches = 0, cmp_count = 0;
  always #2 pclk = ~pclk;
  mvc_regs i_dut (.pclk, .presetn, .is_upstream, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rom_req, .rom_done, .rom_rdata, .irq_event,
    .legacy_int_n, .msg_req, .msg_target, .msg_payload);
  mvc_rom_model i_rom (.pclk, .presetn, .rom_req, .wait_cycles, .rom_done, .rom_rdata);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
    cmp({31'h0, er}, {31'h0, e});
  endtask
  task automatic poll(input logic want);
    int n = 0;
    do
    begin
      apb(1'b0, OFF_PD_ADDR, 32'h0);
      n++;
    end
    while (rd[PD_FLAG_BIT] !== want && n < 100);
    cmp({31'h0, rd[PD_FLAG_BIT]}, {31'h0, want});
  endtask
  task automatic rst(input logic up);
    is_upstream <= up;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic irq(input logic en);
    irq_event <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    cmp({30'h0, msg_req, legacy_int_n}, {30'h0, en, en});
    @(posedge pclk);
    irq_event <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_upstream;
    rst(1'b1);
    rdc(OFF_PD_ADDR, 32'h0000_6403, 1'b0);
    rdc(OFF_PD_WORD, 32'h0, 1'b0);
    rdc(OFF_MSG_CTRL, 32'h0, 1'b1);
    apb(1'b1, OFF_VENDOR, 32'hFFFF_FFFF);
    rdc(OFF_VENDOR, 32'h0034_B009, 1'b0);
    rdc(OFF_TEST0, TEST0_RESET, 1'b0);
    apb(1'b1, OFF_TEST0, 32'h5A5A_A5A5);
    rdc(OFF_TEST0, 32'h5A5A_A5A5, 1'b0);
    apb(1'b1, OFF_PD_WORD, 32'hA5C3_0F96);
    apb(1'b1, OFF_PD_ADDR, 32'h80FC_0000);
    poll(1'b0);
    wait_cycles <= 4'hF;
    apb(1'b1, OFF_PD_WORD, 32'h0);
    apb(1'b1, OFF_PD_ADDR, 32'h7FFF_FFFF);
    poll(1'b1);
    rdc(OFF_PD_WORD, 32'hA5C3_0F96, 1'b0);
    rdc(OFF_PD_ADDR, 32'h80FC_6403, 1'b0);
  endtask
  task automatic t_downstream;
    rst(1'b0);
    rdc(OFF_MSG_CTRL, 32'h0080_6405, 1'b0);
    rdc(OFF_PD_WORD, 32'h0, 1'b1);
    apb(1'b1, OFF_MSG_ADDR, 32'hFFFF_FFFF);
    rdc(OFF_MSG_ADDR, 32'hFFFF_FFFC, 1'b0);
    apb(1'b1, OFF_MSG_DATA, 32'hFFFF_FFFF);
    rdc(OFF_MSG_DATA, 32'h0000_FFFF, 1'b0);
    apb(1'b1, OFF_MSG_UADDR, 32'h1234_5678);
    irq(1'b0);
    apb(1'b1, OFF_MSG_CTRL, 32'hFFFF_FFFF);
    rdc(OFF_MSG_CTRL, 32'h00F1_6405, 1'b0);
    irq(1'b1);
    cmp(msg_target[63:32], 32'h1234_5678);
    cmp(msg_target[31:0], 32'hFFFF_FFFC);
    cmp({16'h0, msg_payload}, 32'h0000_FFFF);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    t_upstream();
    t_downstream();
    conclude();
  end
  initial
  begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
